// file: rtl/tocp_pkg.sv
package tocp_pkg;

    // channel and counter geometry
    localparam int unsigned NCH   = 6;
    localparam int unsigned NPAIR = 3;
    localparam int unsigned CW    = 16;

    // reset and wrap values
    localparam logic [CW-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE   = 16'h0001;
    localparam logic [CW-1:0] CMP_RESET = 16'h0000;

    // pin action on compare, coded as the two edge/level select bits
    typedef enum logic [1:0] {
        TOCP_ACT_NONE   = 2'b00,
        TOCP_ACT_TOGGLE = 2'b01,
        TOCP_ACT_CLEAR  = 2'b10,
        TOCP_ACT_SET    = 2'b11
    } tocp_act_t;

    // per-channel control bits
    typedef struct packed {
        logic      link;
        logic      irq_en;
        tocp_act_t act;
        logic      tov;
        logic      full;
    } tocp_cfg_t;

    // whole state of the block
    typedef struct packed {
        logic [CW-1:0]           cnt;
        logic                    ovf_flag;
        logic [NCH-1:0]          ch_flag;
        logic [NCH-1:0]          pin;
        logic [NPAIR-1:0]        sel;
        logic [NPAIR-1:0]        pend;
        logic [NCH-1:0][CW-1:0]  cmp;
    } tocp_state_t;

endpackage

// file: rtl/tocp_timer.sv
// Summary of operation
// - match sets, clears or toggles channel pin
// - match raises channel request when enabled
// - compare write takes effect at once
// - unsynchronised rewrite may misbehave two periods
// - compare event at match, overflow at wrap
// - link bit pairs channels 0 and 1
// - last written set takes over at overflow
// - even control governs pair, odd pin released
// - same linking for pairs 2/3 and 4/5
// - toggle-on-overflow inverts pin at modulo
// - period equals modulo plus one ticks
// - duty equals compare over period count
// - overflow flag set when counter wraps from modulo to zero
// - no overflow toggle gives 0%, full gives 100%
module tocp_timer (
    // clock and reset
    input  wire logic                                        sys_clk_i,
    input  wire logic                                        rstn_i,
    input  wire logic                                        ce_i,
    // counter control
    input  wire logic                                        tick_i,
    input  wire logic                                        run_i,
    input  wire logic [tocp_pkg::CW-1:0]                     modulo_i,
    input  wire logic                                        ovf_clr_i,
    // channel configuration and compare writes
    input  wire tocp_pkg::tocp_cfg_t [tocp_pkg::NCH-1:0]     cfg_i,
    input  wire logic [tocp_pkg::NCH-1:0]                    cmp_wr_i,
    input  wire logic [tocp_pkg::CW-1:0]                     cmp_wdata_i,
    input  wire logic [tocp_pkg::NCH-1:0]                    ch_clr_i,
    // status
    output logic [tocp_pkg::CW-1:0]                          cnt_o,
    output logic                                             ovf_flag_o,
    output logic [tocp_pkg::NCH-1:0]                         ch_flag_o,
    output logic [tocp_pkg::NCH-1:0]                         ch_irq_o,
    output logic [tocp_pkg::NPAIR-1:0]                       active_sel_o,
    // channel pins
    output logic [tocp_pkg::NCH-1:0]                         pin_o,
    output logic [tocp_pkg::NCH-1:0]                         pin_oe_o
);

    tocp_pkg::tocp_state_t                     s_q;
    tocp_pkg::tocp_state_t                     s_d;
    logic                                      step;
    logic                                      wrap_ev;
    logic [tocp_pkg::CW-1:0]                   cnt_nxt;
    logic [tocp_pkg::NCH-1:0]                  match_ev;
    logic [tocp_pkg::NCH-1:0]                  odd_linked;
    logic [tocp_pkg::NCH-1:0][tocp_pkg::CW-1:0] active_cmp;

    // pin level a compare action leaves behind
    function automatic logic act_level(input tocp_pkg::tocp_act_t act, input logic cur);
        case (act)
            tocp_pkg::TOCP_ACT_CLEAR:  act_level = 1'b0;
            tocp_pkg::TOCP_ACT_SET:    act_level = 1'b1;
            tocp_pkg::TOCP_ACT_TOGGLE: act_level = ~cur;
            default:                   act_level = cur;
        endcase
    endfunction

    function automatic logic is_equal(input logic [tocp_pkg::CW-1:0] a,
                                      input logic [tocp_pkg::CW-1:0] b);
        is_equal = (a == b);
    endfunction

    assign step    = ce_i && tick_i && run_i;
    assign wrap_ev = step && is_equal(s_q.cnt, modulo_i);
    assign cnt_nxt = is_equal(s_q.cnt, modulo_i) ? tocp_pkg::CNT_ZERO
                                                 : s_q.cnt + tocp_pkg::CNT_ONE;

    // duty is compare over period
    // matches are taken on the value the counter steps to, so the pulse starting
    // at wrap lasts exactly compare ticks and duty comes out as compare/period
    always_comb
    begin
        for (int i = 0; i < tocp_pkg::NCH; i++)
        begin
            odd_linked[i] = 1'b0;
            active_cmp[i] = s_q.cmp[i];
            if ((i % 2) == 1)
            begin
                odd_linked[i] = cfg_i[i-1].link;
            end
            else if (cfg_i[i].link && s_q.sel[i/2])
            begin
                active_cmp[i] = s_q.cmp[i+1];
            end
            match_ev[i] = step && !odd_linked[i] && (cfg_i[i].act != tocp_pkg::TOCP_ACT_NONE)
                          && is_equal(cnt_nxt, active_cmp[i]);
        end
    end

    always_comb
    begin
        s_d = s_q;
        if (step)
        begin
            s_d.cnt = cnt_nxt;
        end
        if (ovf_clr_i)
        begin
            s_d.ovf_flag = 1'b0;
        end
        if (wrap_ev)
        begin
            s_d.ovf_flag = 1'b1;
        end
        for (int i = 0; i < tocp_pkg::NCH; i++)
        begin
            if (cmp_wr_i[i])
            begin
                s_d.cmp[i] = cmp_wdata_i;
            end
        end
        for (int p = 0; p < tocp_pkg::NPAIR; p++)
        begin
            if (!cfg_i[2*p].link)
            begin
                s_d.sel[p]  = 1'b0;
                s_d.pend[p] = 1'b0;
            end
            else
            begin
                if (cmp_wr_i[2*p+1])
                begin
                    s_d.pend[p] = 1'b1;
                end
                if (cmp_wr_i[2*p])
                begin
                    s_d.pend[p] = 1'b0;
                end
                if (wrap_ev)
                begin
                    s_d.sel[p] = s_d.pend[p];
                end
            end
        end
        for (int i = 0; i < tocp_pkg::NCH; i++)
        begin
            if (wrap_ev && cfg_i[i].tov && !odd_linked[i])
            begin
                if (cfg_i[i].full)
                begin
                    s_d.pin[i] = ~act_level(cfg_i[i].act, s_q.pin[i]);
                end
                else
                begin
                    s_d.pin[i] = ~s_q.pin[i];
                end
            end
            if (match_ev[i] && !cfg_i[i].full)
            begin
                s_d.pin[i] = act_level(cfg_i[i].act, s_d.pin[i]);
            end
            // channel event flag, set beats clear
            if (ch_clr_i[i])
            begin
                s_d.ch_flag[i] = 1'b0;
            end
            if (match_ev[i])
            begin
                s_d.ch_flag[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_q.cnt      <= tocp_pkg::CNT_ZERO;
            s_q.ovf_flag <= 1'b0;
            s_q.ch_flag  <= '0;
            s_q.pin      <= '0;
            s_q.sel      <= '0;
            s_q.pend     <= '0;
            s_q.cmp      <= {tocp_pkg::NCH{tocp_pkg::CMP_RESET}};
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign cnt_o        = s_q.cnt;
    assign ovf_flag_o   = s_q.ovf_flag;
    assign ch_flag_o    = s_q.ch_flag;
    assign active_sel_o = s_q.sel;
    assign pin_o        = s_q.pin;

    always_comb
    begin
        for (int i = 0; i < tocp_pkg::NCH; i++)
        begin
            ch_irq_o[i] = s_q.ch_flag[i] && cfg_i[i].irq_en && !odd_linked[i];
            // odd pin free for port use
            pin_oe_o[i] = (cfg_i[i].act != tocp_pkg::TOCP_ACT_NONE) && !odd_linked[i];
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // helper: pair 2/3 odd set written last while linked
    logic odd_wr23_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            odd_wr23_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!cfg_i[2].link || cmp_wr_i[2])
            begin
                odd_wr23_q <= 1'b0;
            end
            else if (cmp_wr_i[3])
            begin
                odd_wr23_q <= 1'b1;
            end
        end
    end

    sequence s_wrap_step;
        wrap_ev;
    endsequence

    sequence s_match0;
        match_ev[0] && !cfg_i[0].full;
    endsequence

    AST_WRAP_TO_ZERO: assert property (s_wrap_step |=> (s_q.cnt == tocp_pkg::CNT_ZERO))
        else $error("counter did not wrap to zero at modulo");

    AST_OVF_FLAG: assert property (s_wrap_step |=> ovf_flag_o)
        else $error("overflow flag not set at wrap");

    AST_CLEAR_ON_MATCH: assert property (s_match0 and (cfg_i[0].act == tocp_pkg::TOCP_ACT_CLEAR)
        |=> !pin_o[0])
        else $error("clear action did not drive pin low");

    AST_SET_ON_MATCH: assert property (s_match0 and (cfg_i[0].act == tocp_pkg::TOCP_ACT_SET)
        |=> pin_o[0])
        else $error("set action did not drive pin high");

    AST_IRQ_ON_MATCH: assert property (match_ev[2] && cfg_i[2].irq_en && !ch_clr_i[2]
        |=> ch_irq_o[2] && ch_flag_o[2])
        else $error("match did not raise channel request");

    AST_TOGGLE_ON_OVF: assert property (s_wrap_step and (cfg_i[0].tov && !cfg_i[0].full
        && !match_ev[0]) |=> pin_o[0] != $past(pin_o[0]))
        else $error("pin did not invert at overflow");

    AST_NO_TOV_HOLD: assert property (s_wrap_step and (!cfg_i[4].tov && !match_ev[4])
        |=> $stable(pin_o[4]))
        else $error("pin moved at overflow with toggle disabled");

    AST_ONE_STEP_MATCH: assert property (!step |-> (match_ev == '0))
        else $error("match outside a counter step");

    AST_ODD_RELEASED: assert property (cfg_i[0].link |-> !pin_oe_o[1] && !ch_irq_o[1])
        else $error("odd pin of linked pair still driven");

    AST_BUF_SWAP: assert property (s_wrap_step and (cfg_i[2].link && !cmp_wr_i[2]
        && (odd_wr23_q || cmp_wr_i[3])) |=> active_sel_o[1])
        else $error("written odd set did not take over at overflow");

    AST_UNLINK_EVEN: assert property (!cfg_i[4].link && ce_i |=> !active_sel_o[2])
        else $error("unlinked pair not back on even set");

endmodule

// file: sim/tocp_timer_test.sv
module tocp_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk, rstn, ce, tick, run, oclr, ovf, mo, st, wp;
    logic [15:0]               modv, wd, cnt, r, mc, nc, ac;
    tocp_pkg::tocp_cfg_t [5:0] cfg;
    logic [5:0]                wr, clr, fl, irq, pin, oe, mf, mp, olm, xoe, en;
    logic [5:0][15:0]          mq;
    logic [2:0]                sel, ms, mpd;
    int                        miscompares, num_checks, cyc, hi0, hi2, hi4, z;

    tocp_timer dut_u (.sys_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .tick_i(tick), .run_i(run),
        .modulo_i(modv), .ovf_clr_i(oclr), .cfg_i(cfg), .cmp_wr_i(wr), .cmp_wdata_i(wd),
        .ch_clr_i(clr), .cnt_o(cnt), .ovf_flag_o(ovf), .ch_flag_o(fl), .ch_irq_o(irq),
        .active_sel_o(sel), .pin_o(pin), .pin_oe_o(oe));

    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h exp %h", $time, s, e);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            miscompares++;
            report_and_stop;
        end
    end

    always_comb
        for (int i = 0; i < 6; i++)
        begin
            olm[i] = (i % 2 == 1) && cfg[i - i % 2].link;
            xoe[i] = cfg[i].act != tocp_pkg::TOCP_ACT_NONE && !olm[i];
            en[i] = cfg[i].irq_en;
        end

    // reference of counter, pins, flags and pair select
    always @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            {mc, mo, mf, mp, ms, mpd} = '0;
            mq = '0;
        end
        else if (ce)
        begin
            st = tick & run;
            wp = st && mc == modv;
            nc = wp ? 16'h0000 : mc + 16'h0001;
            mf &= ~clr;
            if (oclr)
                mo = 0;
            if (wp)
                mo = 1;
            for (int i = 0; i < 6; i++)
            begin
                ac = (i % 2 == 0 && cfg[i].link && ms[i / 2]) ? mq[i + 1] : mq[i];
                if (st && !olm[i] && cfg[i].act != tocp_pkg::TOCP_ACT_NONE)
                begin
                    if (wp && cfg[i].tov)
                        mp[i] = cfg[i].full ? cfg[i].act == tocp_pkg::TOCP_ACT_CLEAR : ~mp[i];
                    if (nc == ac)
                    begin
                        mf[i] = 1;
                        if (!cfg[i].full)
                            mp[i] = cfg[i].act == tocp_pkg::TOCP_ACT_TOGGLE ? ~mp[i] : cfg[i].act[0];
                    end
                end
                if (wr[i])
                    mq[i] = wd;
            end
            for (int p = 0; p < 3; p++)
            begin
                if (wr[2 * p + 1])
                    mpd[p] = 1;
                if (wr[2 * p])
                    mpd[p] = 0;
                if (wp)
                    ms[p] = mpd[p];
                if (!cfg[2 * p].link)
                    {ms[p], mpd[p]} = 2'b00;
            end
            if (st)
                mc = nc;
        end

    always @(negedge clk)
        if (rstn)
        begin
            check(cnt, mc);
            check(ovf, mo);
            check(fl & ~olm, mf & ~olm);
            check(irq, mf & en & ~olm);
            check(sel, ms);
            check(oe, xoe);
            check(pin & xoe, mp & xoe);
        end

    initial
    begin
        r = 16'h0014;
        {rstn, ce, tick, run, oclr, wr, clr, wd} = '0;
        cfg = '0;
        modv = 16'h00FF;
        repeat (20) @(posedge clk);
        #1 rstn = 1;
        ce = 1;
        tick = 1;
        run = 1;
        // clear on compare gives high pulse
        cfg[0] = '{1'b0, 1'b1, tocp_pkg::TOCP_ACT_CLEAR, 1'b1, 1'b0};
        cfg[2] = '{1'b0, 1'b0, tocp_pkg::TOCP_ACT_CLEAR, 1'b1, 1'b1};
        cfg[4] = '{1'b0, 1'b0, tocp_pkg::TOCP_ACT_CLEAR, 1'b0, 1'b0};
        wr = 6'h01;
        wd = 16'h0080;
        @(posedge clk) #1 wr = 6'h00;
        repeat (300) @(posedge clk);
        repeat (512)
        begin
            @(negedge clk);
            hi0 += pin[0];
            hi2 += pin[2];
            hi4 += pin[4];
            z += cnt == 16'h0000;
        end
        check(z, 2);
        check(hi0, 256);
        check(hi2, 512);
        check(hi4, 0);
        @(posedge clk) #1 rstn = 0;
        modv = 16'h000F;
        repeat (3) @(posedge clk);
        #1 rstn = 1;
        for (int k = 0; k < 6000; k++)
        begin
            r = nx(r);
            ce = r[15:13] != 0;
            tick = r[12:10] != 0;
            run = r[9:7] != 0;
            oclr = r[6:4] == 0;
            r = nx(nx(r));
            wr = r[5:0] & r[11:6] & {6{r[12]}};
            clr = r[11:6] & r[15:10];
            wd = 16'h0001 + r % 16'h000F;
            if (k % 64 == 0)
                for (int i = 0; i < 6; i++)
                begin
                    r = nx(nx(nx(r)));
                    cfg[i] = '{r[0], r[1], tocp_pkg::tocp_act_t'(2'(1 + r % 3)), r[2], 1'b0};
                end
            @(posedge clk) #1;
        end
        report_and_stop;
    end
endmodule
